// >>> hdl/ssp_top.sv
// Synchronous serial port: data FIFO and serial engine
`default_nettype none

// ****************************************
// Data FIFO
// ****************************************
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Depth must be a power of two so the pointers wrap on their own
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

module ssp_top
  import ssp_pkg::*;
#(
  parameter int DIV_W = 8,
  parameter int TIMEOUT_CYCLES = RX_TIMEOUT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic port_enable,
  input wire logic [2:0] frame_format,
  input wire logic [1:0] role,
  input wire logic [4:0] data_width,
  input wire logic [DIV_W-1:0] half_period,
  input wire logic dma_rx_enable,
  input wire logic dma_tx_enable,
  input wire logic [3:0] irq_mask,
  input wire logic [1:0] irq_clear,
  input wire logic [31:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [15:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic busy,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic [3:0] irq_raw,
  output logic [3:0] irq_masked,
  output logic irq,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic frame_in,
  output logic frame_out,
  output logic frame_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] clamp_width(input logic [4:0] w);
    if (w < WIDTH_MIN) begin
      return WIDTH_MIN;
    end else if (w > WIDTH_MAX) begin
      return WIDTH_MAX;
    end
    return w;
  endfunction

  function automatic logic [15:0] low_mask(input logic [4:0] w);
    logic [31:0] ones;
    ones = (32'h0000_0001 << w) - 32'h0000_0001;
    return ones[15:0];
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic sclk_s1, sclk_s2, sclk_s3;
  logic frame_s1, frame_s2;
  logic sdi_s1, sdi_s2;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      frame_s1 <= 1'b1;
      frame_s2 <= 1'b1;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_in;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      frame_s1 <= frame_in;
      frame_s2 <= frame_s1;
      sdi_s1 <= sdi;
      sdi_s2 <= sdi_s1;
    end
  end

  // ****************************************
  // Configuration decode
  // ****************************************
  logic cpol, cpha, is_ti, is_cr, is_master;
  logic [4:0] width;
  logic [4:0] frame_len;

  assign is_ti = frame_format == pulse_framed_format;
  assign is_cr = frame_format == command_response_format;
  assign cpol = ~frame_format[2] & frame_format[1];
  assign cpha = is_ti | (~frame_format[2] & frame_format[0]);
  assign is_master = role == role_master;
  assign width = clamp_width(data_width);
  // Command phase, one turnaround bit, then the response
  assign frame_len = is_cr ? 5'(width + CMD_TURN_BITS) : width;

  // ****************************************
  // FIFOs
  // ****************************************
  logic [15:0] tx_head;
  logic tx_head_valid, tx_pop;
  logic [3:0] tx_count, rx_count;
  logic rx_push, rx_in_ready;
  logic [15:0] rx_word, rx_head;
  logic rx_head_valid, rx_head_take;

  ssp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data(tx_data[15:0] & low_mask(width)),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(tx_head),
    .out_valid(tx_head_valid),
    .out_ready(tx_pop),
    .count(tx_count)
  );

  ssp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_data(rx_word),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .out_data(rx_head),
    .out_valid(rx_head_valid),
    .out_ready(rx_head_take),
    .count(rx_count)
  );

  // Output stage keeps rx outputs on flops
  assign rx_head_take = ~rx_valid | rx_ready;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_valid <= 1'b0;
      rx_data <= 16'h0000;
    end else if (rx_head_take) begin
      rx_valid <= rx_head_valid;
      rx_data <= rx_head;
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  ssp_state_type state;
  logic [DIV_W-1:0] div_cnt;
  logic tick, lead, trail, sample_ev, drive_ev, done;
  logic slave_start, frame_active_in;
  logic [4:0] sample_cnt;
  logic [15:0] tx_shift, rx_shift;

  // Clock in both roles is ref_clk; no second domain
  assign tick = div_cnt == half_period;
  assign frame_active_in = is_ti ? frame_s2 : ~frame_s2;
  assign slave_start = ~is_master & frame_active_in;
  // Slave edge detect needs the 12x margin to see each bit
  always_comb begin
    if (is_master) begin
      lead = state == st_shift && tick && sclk_out == cpol;
      trail = state == st_shift && tick && sclk_out != cpol;
    end else begin
      lead = state == st_shift && sclk_s2 != sclk_s3 && sclk_s3 == cpol;
      trail = state == st_shift && sclk_s2 != sclk_s3 && sclk_s3 != cpol;
    end
  end
  assign sample_ev = cpha ? trail : lead;
  assign drive_ev = cpha ? (lead && sample_cnt != 5'h00) : trail;
  assign done = trail && 5'(sample_cnt + {4'h0, cpha}) == frame_len;
  assign tx_pop = state == st_idle && port_enable && tx_head_valid
                  && (is_master || slave_start);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= st_idle;
      div_cnt <= '0;
      sclk_out <= 1'b0;
    end else if (!port_enable) begin
      state <= st_idle;
      div_cnt <= '0;
      sclk_out <= cpol;
    end else begin
      div_cnt <= (tick || state == st_idle) ? '0 : div_cnt + 1'b1;
      case (state)
        st_idle: begin
          sclk_out <= cpol;
          if (is_master && tx_head_valid) begin
            state <= st_start;
          end else if (slave_start) begin
            state <= st_shift;
          end
        end
        st_start: begin
          if (tick) begin
            state <= st_shift;
          end
        end
        st_shift: begin
          if (is_master && tick) begin
            sclk_out <= ~sclk_out;
          end
          // Slave aborts when the master drops the frame early
          if (done || (slave_start == 1'b0 && !is_master && !is_ti)) begin
            state <= st_idle;
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      sample_cnt <= 5'h00;
    end else if (state == st_idle) begin
      sample_cnt <= 5'h00;
      // Left-aligned so bit 15 leaves first
      if (tx_pop) begin
        tx_shift <= is_cr ? {tx_head[7:0], 8'h00}
                          : 16'(tx_head << 5'(WIDTH_MAX - width));
      end else if (slave_start) begin
        tx_shift <= 16'h0000;
      end
    end else begin
      if (drive_ev) begin
        tx_shift <= {tx_shift[14:0], 1'b0};
      end
      if (sample_ev) begin
        sample_cnt <= sample_cnt + 5'h01;
        if (!is_cr || sample_cnt >= CMD_TURN_BITS) begin
          rx_shift <= {rx_shift[14:0], sdi_s2};
        end
      end
    end
  end

  // Word lands one cycle after the closing edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_push <= 1'b0;
    end else begin
      rx_push <= done;
    end
  end
  assign rx_word = rx_shift & low_mask(width);

  // ****************************************
  // Pin drivers and status
  // ****************************************
  assign sdo = tx_shift[15];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_out <= 1'b1;
      frame_oe <= 1'b0;
      sclk_oe <= 1'b0;
      sdo_oe <= 1'b0;
      busy <= 1'b0;
    end else begin
      frame_out <= is_ti ? state == st_start : state == st_idle;
      frame_oe <= is_master && port_enable;
      sclk_oe <= is_master && port_enable;
      // Output-off slave leaves the line to its neighbours
      sdo_oe <= port_enable && (is_master
                || (role == role_slave && state == st_shift));
      busy <= tx_head_valid || state != st_idle;
    end
  end

  // ****************************************
  // DMA requests and interrupt sources
  // ****************************************
  logic [15:0] idle_cnt;
  logic timeout_flag, overrun_flag;
  logic [3:0] next_raw;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idle_cnt <= 16'h0000;
      timeout_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      idle_cnt <= (state != st_idle || rx_count == 4'h0) ? 16'h0000
                  : (idle_cnt == 16'(TIMEOUT_CYCLES) ? idle_cnt : idle_cnt + 16'h0001);
      // Set wins over a clear in the same cycle
      if (idle_cnt == 16'(TIMEOUT_CYCLES) - 16'h0001) begin
        timeout_flag <= 1'b1;
      end else if (irq_clear[0]) begin
        timeout_flag <= 1'b0;
      end
      if (rx_push && !rx_in_ready) begin
        overrun_flag <= 1'b1;
      end else if (irq_clear[1]) begin
        overrun_flag <= 1'b0;
      end
    end
  end

  always_comb begin
    next_raw = 4'h0;
    next_raw[IRQ_TX_LEVEL] = tx_count <= FIFO_LEVEL;
    next_raw[IRQ_RX_LEVEL] = rx_count >= FIFO_LEVEL;
    next_raw[IRQ_RX_TIMEOUT] = timeout_flag;
    next_raw[IRQ_RX_OVERRUN] = overrun_flag;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_raw <= 4'h0;
      irq_masked <= 4'h0;
      irq <= 1'b0;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
    end else begin
      irq_raw <= next_raw;
      irq_masked <= next_raw & irq_mask;
      irq <= |(next_raw & irq_mask);
      dma_tx_req <= dma_tx_enable && tx_count <= FIFO_LEVEL;
      dma_rx_req <= dma_rx_enable && rx_head_valid;
    end
  end
endmodule
`default_nettype wire

// >>> shared/ssp_pkg.sv
// Shared constants and types for the synchronous serial port
`default_nettype none
package ssp_pkg;
  typedef enum logic [2:0] {
    spi_mode_pol0_pha0 = 3'b000,
    spi_mode_pol0_pha1 = 3'b001,
    spi_mode_pol1_pha0 = 3'b010,
    spi_mode_pol1_pha1 = 3'b011,
    pulse_framed_format = 3'b100,
    command_response_format = 3'b101
  } ssp_format_type;
  typedef enum logic [1:0] {
    role_master = 2'b00,
    role_slave = 2'b01,
    role_slave_output_off = 2'b10
  } ssp_role_type;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_start = 2'b01,
    st_shift = 2'b10
  } ssp_state_type;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_W = 16;
  localparam logic [4:0] WIDTH_MIN = 5'h04;
  localparam logic [4:0] WIDTH_MAX = 5'h10;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] CMD_TURN_BITS = 5'h09;
  localparam logic [3:0] FIFO_LEVEL = 4'h4;
  localparam int RX_TIMEOUT_CYCLES = 640;
  localparam int IRQ_TX_LEVEL = 0;
  localparam int IRQ_RX_LEVEL = 1;
  localparam int IRQ_RX_TIMEOUT = 2;
  localparam int IRQ_RX_OVERRUN = 3;
endpackage
`default_nettype wire

// >>> dv/ssp_checker_properties.sv
// Port-level assertions for the synchronous serial port
`default_nettype none
module ssp_checker
  import ssp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic port_enable,
  input wire logic [2:0] frame_format,
  input wire logic [1:0] role,
  input wire logic [4:0] data_width,
  input wire logic dma_rx_enable,
  input wire logic dma_tx_enable,
  input wire logic [3:0] irq_mask,
  input wire logic [1:0] irq_clear,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [15:0] rx_data,
  input wire logic rx_valid,
  input wire logic busy,
  input wire logic dma_tx_req,
  input wire logic dma_rx_req,
  input wire logic [3:0] irq_raw,
  input wire logic [3:0] irq_masked,
  input wire logic irq,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  chk_busy_after_push: assert property (tx_valid && tx_ready |-> ##[1:2] busy)
    else $error("busy late");
  chk_full_means_busy: assert property (!tx_ready ##1 !tx_ready |-> busy)
    else $error("full but idle");
  chk_dma_tx_full: assert property (!tx_ready ##1 !tx_ready |-> !dma_tx_req)
    else $error("tx request while full");
  chk_output_off_role: assert property (role == role_slave_output_off |-> !sdo_oe)
    else $error("data driven in output-off role");
  chk_stop_on_disable: assert property (!port_enable ##1 !port_enable |-> !sclk_oe && !sdo_oe)
    else $error("pins driven while off");
  // Busy lags a cycle, but the start period covers that gap
  chk_sclk_idle_level: assert property (port_enable && $past(port_enable) && !busy &&
    role == role_master && !frame_format[2] |-> sclk_out == frame_format[1])
    else $error("idle clock level");
  chk_rx_width_mask: assert property (rx_valid && data_width >= WIDTH_MIN &&
    data_width <= WIDTH_MAX |-> (rx_data >> data_width) == 16'h0000)
    else $error("bits above width");
  chk_dma_tx_off: assert property (!dma_tx_enable |=> !dma_tx_req)
    else $error("tx request disabled");
  chk_dma_rx_off: assert property (!dma_rx_enable |=> !dma_rx_req)
    else $error("rx request disabled");
  chk_irq_masking: assert property ($stable(irq_mask) && $stable(irq_raw) |->
    irq_masked == (irq_raw & irq_mask) && irq == |irq_masked)
    else $error("masked status");
  chk_overrun_sticky: assert property (irq_raw[IRQ_RX_OVERRUN] && !irq_clear[1] &&
    !$past(irq_clear[1]) |=> irq_raw[IRQ_RX_OVERRUN])
    else $error("overrun lost");
endmodule
`default_nettype wire

// >>> dv/ssp_peer.sv
// Behavioural serial slave that echoes the previous frame
`default_nettype none
module ssp_peer (
  input wire logic sclk,
  input wire logic frame_sig,
  input wire logic sdo,
  input wire logic [2:0] fmt,
  input wire logic [4:0] width,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] shreg = 16'h0000;
  logic active = 1'b0;
  int cnt;
  logic pol;
  logic pha;
  // ****************************************
  // Model
  // ****************************************
  assign pol = fmt[1] & ~fmt[2];
  assign pha = fmt[0] | fmt[2];
  initial sdi = 1'b1;
  always @(frame_sig) begin
    if (frame_sig == (fmt == 3'h4)) begin
      active = 1'b1;
      cnt = 0;
      sdi = shreg[width-1];
    end else if (fmt != 3'h4) begin
      // Released line must not look like held data
      active = 1'b0;
      sdi = ~sdi;
    end
  end
  // Gated by the frame so idle-level moves never shift
  always @(sclk) begin
    if (active && sclk === (pol ~^ pha)) begin
      shreg = {shreg[14:0], sdo};
      cnt++;
      if (cnt == int'(width)) active = 1'b0;
    end else if (active) begin
      sdi = shreg[width-1];
    end
  end
endmodule
`default_nettype wire

// >>> dv/sync_serial_port_tb.sv
// Self-checking bench for the synchronous serial port
`default_nettype none
module sync_serial_port_tb
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CMP(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t %h %h", $time, a, b); end end
  logic ref_clk, rst_n, port_enable, dma_rx_enable, dma_tx_enable, tx_valid, tx_ready;
  logic rx_valid, rx_ready, busy, dma_tx_req, dma_rx_req, irq, sclk_out, sclk_oe;
  logic frame_out, frame_oe, sdi, sdo, sdo_oe;
  logic [2:0] frame_format;
  logic [1:0] role, irq_clear;
  logic [4:0] data_width;
  logic [7:0] half_period;
  logic [3:0] irq_mask, irq_raw, irq_masked;
  logic [31:0] tx_data, seed;
  logic [15:0] rx_data, pm;
  logic [15:0] exp_q[$];
  int num_errors, n_checks;
  ssp_top #(.TIMEOUT_CYCLES(20)) dut_u (.ref_clk, .rst_n, .port_enable, .frame_format, .role,
    .data_width, .half_period, .dma_rx_enable, .dma_tx_enable, .irq_mask, .irq_clear, .tx_data,
    .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .busy, .dma_tx_req, .dma_rx_req,
    .irq_raw, .irq_masked, .irq, .sclk_in(1'b0), .sclk_out, .sclk_oe, .frame_in(1'b1),
    .frame_out, .frame_oe, .sdi, .sdo, .sdo_oe);
  ssp_peer peer_u (.sclk(sclk_out), .frame_sig(frame_out), .sdo, .fmt(frame_format),
    .width(data_width), .sdi);
  // ****************************************
  // Bench
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] mask(input logic [4:0] n);
    return 16'((32'h0000_0001 << n) - 1);
  endfunction
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Echo model: the peer returns what it shifted in last time
  task automatic push(input logic [31:0] w);
    tx_data = w;
    tx_valid = 1'b1;
    if (tx_ready === 1'b1) begin
      exp_q.push_back(pm & mask(data_width));
      pm = (pm << data_width) | (w[15:0] & mask(data_width));
    end
    tick(1);
  endtask
  task automatic wait_idle();
    int i;
    tick(3);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) tick(1);
    if (i == 3000) begin
      num_errors++;
      final_report();
    end
    tick(4);
  endtask
  task automatic pop(input logic [15:0] e);
    int i;
    tick(1);
    for (i = 0; i < 50 && rx_valid !== 1'b1; i++) tick(1);
    if (i == 50) begin
      num_errors++;
      final_report();
    end
    `CMP(rx_data, e)
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask
  task automatic cfg(input logic [2:0] f, input logic [4:0] n, input logic [1:0] r);
    port_enable = 1'b0;
    tick(2);
    frame_format = f;
    data_width = n;
    role = r;
    tick(2);
    port_enable = 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    port_enable = 1'b0;
    frame_format = 3'h0;
    role = 2'h0;
    data_width = 5'h08;
    half_period = 8'h03;
    dma_rx_enable = 1'b0;
    dma_tx_enable = 1'b1;
    irq_mask = 4'hf;
    irq_clear = 2'h0;
    tx_data = 32'h0000_0000;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    seed = 32'h4392_a84b;
    pm = 16'h0000;
    tick(6);
    rst_n = 1'b1;
    tick(2);
    `CMP({tx_ready, busy}, 2'b10)
    `CMP(irq_raw[IRQ_TX_LEVEL], 1'b1)
    for (int k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      push(seed);
    end
    tx_valid = 1'b0;
    `CMP(tx_ready, 1'b0)
    `CMP({busy, dma_tx_req}, 2'b10)
    port_enable = 1'b1;
    wait_idle();
    `CMP({dma_tx_req, frame_out}, 2'b11)
    for (int k = 0; k < 2; k++) push(~k);
    tx_valid = 1'b0;
    wait_idle();
    tick(25);
    `CMP({irq_raw[3:2], irq}, 3'b111)
    irq_mask = 4'h0;
    dma_rx_enable = 1'b1;
    dma_tx_enable = 1'b0;
    tick(3);
    `CMP({irq, dma_rx_req, dma_tx_req}, 3'b010)
    irq_clear = 2'b10;
    tick(1);
    irq_clear = 2'b00;
    tick(3);
    `CMP(irq_raw[3:2], 2'b01)
    // Only nine fit: eight stored plus the output stage
    for (int k = 0; k < 9; k++) pop(exp_q.pop_front());
    exp_q.delete();
    irq_mask = seed[3:0];
    tick(2);
    `CMP(rx_valid, 1'b0)
    irq_clear = 2'b01;
    tick(1);
    irq_clear = 2'b00;
    tick(3);
    `CMP(irq_raw[2], 1'b0)
    for (int f = 1; f < 5; f++) begin
      seed = lfsr(seed);
      cfg(3'(f), (f == 1) ? 5'h04 : (f == 2) ? 5'h10 : 5'(4 + seed % 13), 2'h0);
      push(seed);
      push(~seed);
      tx_valid = 1'b0;
      `CMP({sclk_oe, frame_oe}, 2'b11)
      wait_idle();
      pop(exp_q.pop_front());
      pop(exp_q.pop_front());
    end
    cfg(3'h0, 5'h08, 2'h2);
    tick(3);
    `CMP({sclk_oe, sdo_oe}, 2'b00)
    cfg(3'h0, 5'h08, 2'h1);
    tick(3);
    `CMP(sclk_oe, 1'b0)
    cfg(3'h5, 5'h0c, 2'h0);
    seed = lfsr(seed);
    push(seed);
    tx_valid = 1'b0;
    wait_idle();
    `CMP(rx_valid, 1'b1)
    `CMP(rx_data[15:12], 4'h0)
    final_report();
  end
endmodule
bind ssp_top ssp_checker chk_u (.ref_clk, .rst_n, .port_enable, .frame_format, .role,
  .data_width, .dma_rx_enable, .dma_tx_enable, .irq_mask, .irq_clear, .tx_valid, .tx_ready,
  .rx_data, .rx_valid, .busy, .dma_tx_req, .dma_rx_req, .irq_raw, .irq_masked, .irq,
  .sclk_out, .sclk_oe, .sdo_oe);
`default_nettype wire
